// File: pkg/fbc_pkg.sv
// package: constants and types for the flash bus controller
package fbc_pkg;
   // ======================================================
   // register map (word byte addresses)
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] ADDR_OFS = 4'h4;
   localparam logic [3:0] WDATA_OFS = 4'h8;
   localparam logic [3:0] RDATA_OFS = 4'hC;
   // ======================================================
   // control fields
   localparam int CMD_LSB = 0;
   localparam int BYTE_MODE_BIT = 4;
   localparam int HV_ID_BIT = 5;
   localparam int START_BIT = 31;
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_RESET = 3'h3;
   localparam logic [2:0] CMD_UNPROT_WR = 3'h4;
   // status fields
   localparam int BUSY_BIT = 8;
   localparam int RDY_BIT = 9;
   // ======================================================
   // widths and reset values
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   // ======================================================
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int ACCESS_NS = 150;
   localparam int WE_PULSE_NS = 50;
   localparam int RESET_PULSE_MIN_NS = 500;
   localparam int POST_RESET_READ_HOLD_NS = 50;
   localparam int RESET_READY_NS = 20000;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_MIN_CYC =
      (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POST_RESET_READ_HOLD_CYC =
      (POST_RESET_READ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_READY_CYC = RESET_READY_NS / CLK_PERIOD_NS;
   localparam int SYNC_CYC = 2;
   localparam int CNT_W = 16;
   // ======================================================
   typedef enum logic [2:0] {
      FBC_IDLE, FBC_READ, FBC_WRITE, FBC_RST_LOW, FBC_RST_WAIT, FBC_HOLD
   } fbc_state_e;
endpackage : fbc_pkg

// File: rtl/fbc_sync.sv
// two-flop synchroniser
`timescale 1ns/1ps
module fbc_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : fbc_sync

// File: rtl/fbc_host.sv
// host-side controller for a parallel flash bus
`timescale 1ns/1ps
// How it works
// - read drives chip select and output enable low, write enable and reset high.
// - write drives write enable and chip select low, output enable high.
// - reads wait post-reset hold after reset release.
// - software reissues operations cut short by reset.
module fbc_host (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic wr_en_n,
   output logic reset_n,
   output logic high_voltage_id_level,
   output logic byte_mode_n,
   output logic [18:0] flash_addr,
   input wire logic [14:0] flash_dq_in,
   output logic [14:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic data_bit_top_in,
   output logic data_bit_top_out,
   output logic data_bit_top_oe,
   input wire logic ready_busy_n
);
   // ======================================================
   // registers
   fbc_pkg::fbc_state_e state;
   fbc_pkg::fbc_state_e next_state;
   logic [2:0] cmd;
   logic byte_mode;
   logic hv_req;
   logic [fbc_pkg::ADDR_W-1:0] addr;
   logic [fbc_pkg::DATA_W-1:0] wdata;
   logic [fbc_pkg::DATA_W-1:0] rdata;
   logic [fbc_pkg::CNT_W-1:0] cnt;
   logic rdy_sync;
   logic [14:0] dq_sync;
   logic top_sync;
   logic rd_ack;
   // ======================================================
   // synchronisers for pins
   fbc_sync u_rb (.core_clk(core_clk), .rst(rst), .din(ready_busy_n), .dout(rdy_sync));
   fbc_sync u_top (.core_clk(core_clk), .rst(rst), .din(data_bit_top_in), .dout(top_sync));
   genvar gi;
   generate
      for (gi = 0; gi < 15; gi++) begin : g_dq
         fbc_sync u_dq (.core_clk(core_clk), .rst(rst), .din(flash_dq_in[gi]),
            .dout(dq_sync[gi]));
      end
   endgenerate
   // ======================================================
   // bus decode
   wire busy = (state != fbc_pkg::FBC_IDLE);
   wire wr_ctrl = avs_write && (avs_address == fbc_pkg::CTRL_OFS);
   wire wr_addr = avs_write && (avs_address == fbc_pkg::ADDR_OFS) && !busy;
   wire wr_data = avs_write && (avs_address == fbc_pkg::WDATA_OFS) && !busy;
   wire start = wr_ctrl && !busy && avs_writedata[fbc_pkg::START_BIT];
   wire [2:0] new_cmd = avs_writedata[fbc_pkg::CMD_LSB +: 3];
   wire cnt_done = (cnt == '0);
   wire [31:0] ctrl_rd = {22'h000000, rdy_sync, busy, 2'h0, hv_req, byte_mode, 1'b0, cmd};
   assign avs_waitrequest = avs_read && !rd_ack;
   // ======================================================
   // pin decode
   wire in_read = (state == fbc_pkg::FBC_READ);
   wire in_write = (state == fbc_pkg::FBC_WRITE);
   wire in_rst = (state == fbc_pkg::FBC_RST_LOW);
   assign chip_sel_n = !(in_read || in_write);
   assign out_en_n = !in_read;
   assign wr_en_n = !in_write;
   assign reset_n = !in_rst;
   assign high_voltage_id_level = hv_req && in_write;
   assign byte_mode_n = !byte_mode;
   assign flash_addr = addr[fbc_pkg::ADDR_W-1:1];
   assign flash_dq_oe = in_write;
   assign flash_dq_out = byte_mode ? {7'h00, wdata[7:0]} : wdata[14:0];
   assign data_bit_top_oe = in_write || byte_mode;
   assign data_bit_top_out = byte_mode ? addr[0] : wdata[15];
   // ======================================================
   // next state
   always_comb begin
      next_state = state;
      case (state)
         fbc_pkg::FBC_IDLE: begin
            if (start) begin
               case (new_cmd)
                  fbc_pkg::CMD_READ: next_state = fbc_pkg::FBC_READ;
                  fbc_pkg::CMD_WRITE: next_state = fbc_pkg::FBC_WRITE;
                  fbc_pkg::CMD_UNPROT_WR: next_state = fbc_pkg::FBC_WRITE;
                  fbc_pkg::CMD_RESET: next_state = fbc_pkg::FBC_RST_LOW;
                  default: next_state = fbc_pkg::FBC_IDLE;
               endcase
            end
         end
         fbc_pkg::FBC_READ: if (cnt_done) next_state = fbc_pkg::FBC_IDLE;
         fbc_pkg::FBC_WRITE: if (cnt_done) next_state = fbc_pkg::FBC_IDLE;
         fbc_pkg::FBC_RST_LOW: if (cnt_done) next_state = fbc_pkg::FBC_RST_WAIT;
         fbc_pkg::FBC_RST_WAIT: begin
            if (rdy_sync || cnt_done) next_state = fbc_pkg::FBC_HOLD;
         end
         fbc_pkg::FBC_HOLD: if (cnt_done) next_state = fbc_pkg::FBC_IDLE;
         default: next_state = fbc_pkg::FBC_IDLE;
      endcase
   end
   // ======================================================
   // counter load values
   logic [fbc_pkg::CNT_W-1:0] next_cnt;
   always_comb begin
      next_cnt = (cnt_done) ? cnt : cnt - 1'b1;
      if (next_state != state) begin
         case (next_state)
            fbc_pkg::FBC_READ: begin
               next_cnt = fbc_pkg::CNT_W'(fbc_pkg::ACCESS_CYC + fbc_pkg::SYNC_CYC);
            end
            fbc_pkg::FBC_WRITE: next_cnt = fbc_pkg::CNT_W'(fbc_pkg::WE_PULSE_CYC);
            fbc_pkg::FBC_RST_LOW: next_cnt = fbc_pkg::CNT_W'(fbc_pkg::RESET_PULSE_MIN_CYC);
            fbc_pkg::FBC_RST_WAIT: next_cnt = fbc_pkg::CNT_W'(fbc_pkg::RESET_READY_CYC);
            fbc_pkg::FBC_HOLD: next_cnt = fbc_pkg::CNT_W'(fbc_pkg::POST_RESET_READ_HOLD_CYC);
            default: next_cnt = '0;
         endcase
      end
   end
   // ======================================================
   // sequencer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= fbc_pkg::FBC_IDLE;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end
   // ======================================================
   // software registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd <= fbc_pkg::CTRL_RST[2:0];
         byte_mode <= 1'b0;
         hv_req <= 1'b0;
         addr <= '0;
         wdata <= '0;
      end else begin
         if (wr_ctrl && !busy) begin
            cmd <= new_cmd;
            byte_mode <= avs_writedata[fbc_pkg::BYTE_MODE_BIT];
            hv_req <= (new_cmd == fbc_pkg::CMD_UNPROT_WR);
         end
         if (wr_addr) addr <= avs_writedata[fbc_pkg::ADDR_W-1:0];
         if (wr_data) wdata <= avs_writedata[fbc_pkg::DATA_W-1:0];
      end
   end
   // ======================================================
   // read capture: array, identifier or status, all same timing
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (in_read && cnt_done) begin
         rdata <= byte_mode ? {8'h00, dq_sync[7:0]} : {top_sync, dq_sync};
      end
   end
   // ======================================================
   // one wait state per read, data stands at the accept edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_ack <= 1'b0;
      end else begin
         rd_ack <= avs_read && !rd_ack;
      end
   end
   // ======================================================
   // read mux, registered data
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= '0;
      end else if (avs_read) begin
         case (avs_address)
            fbc_pkg::CTRL_OFS: avs_readdata <= ctrl_rd;
            fbc_pkg::ADDR_OFS: avs_readdata <= {12'h000, addr};
            fbc_pkg::WDATA_OFS: avs_readdata <= {16'h0000, wdata};
            fbc_pkg::RDATA_OFS: avs_readdata <= {16'h0000, rdata};
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end
endmodule : fbc_host

// File: tb/fbc_checker.sv
// checker: flash control pin relations
`timescale 1ns/1ps
module fbc_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic reset_n,
   input wire logic high_voltage_id_level,
   input wire logic byte_mode_n,
   input wire logic flash_dq_oe,
   input wire logic data_bit_top_oe
);
   // ======================================================
   // reset pulse length counter
   logic [7:0] low_cnt;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) low_cnt <= 8'h00;
      else if (reset_n) low_cnt <= 8'h00;
      else low_cnt <= low_cnt + 8'h01;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ======================================================
   property p_rd; !out_en_n |-> !chip_sel_n && wr_en_n && reset_n; endproperty
   a_rd: assert property (p_rd) else $error("read levels wrong");
   property p_wr; !wr_en_n |-> !chip_sel_n && out_en_n && reset_n; endproperty
   a_wr: assert property (p_wr) else $error("write levels wrong");
   property p_acc; $fell(out_en_n) |-> !out_en_n [*7]; endproperty
   a_acc: assert property (p_acc) else $error("read access too short");
   property p_hiz; flash_dq_oe |-> out_en_n; endproperty
   a_hiz: assert property (p_hiz) else $error("driving data while reading");
   property p_sby; !reset_n |-> chip_sel_n && out_en_n && wr_en_n && !flash_dq_oe; endproperty
   a_sby: assert property (p_sby) else $error("activity during reset");
   property p_rlen; $rose(reset_n) |-> low_cnt >= fbc_pkg::RESET_PULSE_MIN_CYC; endproperty
   a_rlen: assert property (p_rlen) else $error("reset pulse too short");
   property p_hold; $rose(reset_n) |-> out_en_n [*3]; endproperty
   a_hold: assert property (p_hold) else $error("read too soon after reset");
   property p_hv; high_voltage_id_level |-> reset_n; endproperty
   a_hv: assert property (p_hv) else $error("high voltage with reset low");
   property p_tb; !byte_mode_n && !out_en_n |-> data_bit_top_oe; endproperty
   a_tb: assert property (p_tb) else $error("byte address pin not driven");
   property p_tw; byte_mode_n && data_bit_top_oe |-> flash_dq_oe; endproperty
   a_tw: assert property (p_tw) else $error("top pin driven alone");
endmodule : fbc_checker
bind fbc_host fbc_checker fbc_checker_i (.core_clk(core_clk), .rst(rst),
   .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .reset_n(reset_n),
   .high_voltage_id_level(high_voltage_id_level), .byte_mode_n(byte_mode_n),
   .flash_dq_oe(flash_dq_oe), .data_bit_top_oe(data_bit_top_oe));

// File: tb/fbc_flash.sv
// partner model: behavioural parallel flash
`timescale 1ns/1ps
module fbc_flash #(
   parameter int ACC_NS = 150,
   parameter int READY_NS = 5000,
   parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
) (
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic reset_n,
   input wire logic high_voltage_id_level,
   input wire logic byte_mode_n,
   input wire logic [18:0] flash_addr,
   input wire logic [14:0] dq_wire,
   input wire logic top_wire,
   output logic [14:0] dq_drv,
   output logic top_drv,
   output logic ready_busy_n
);
   logic [15:0] mem [0:15];
   logic [15:0] lat_d;
   logic [15:0] last = 16'h0000;
   logic [3:0] lat_a;
   logic lat_v = 1'b0;
   logic auto_sel = 1'b0;
   logic acc_ok;
   wire rd_en = !chip_sel_n && !out_en_n && wr_en_n && reset_n;
   assign #(ACC_NS) acc_ok = rd_en;
   wire drive = rd_en && acc_ok;
   wire [15:0] aw = auto_sel ? {8'h00, ID_CODE} : mem[flash_addr[3:0]];
   wire [15:0] word = byte_mode_n ? aw : {8'h00, top_wire ? aw[15:8] : aw[7:0]};
   assign dq_drv[7:0] = drive ? word[7:0] : ~last[7:0];
   assign dq_drv[14:8] = (drive && byte_mode_n) ? word[14:8] : ~last[14:8];
   assign top_drv = (drive && byte_mode_n) ? word[15] : ~last[15];
   initial begin
      ready_busy_n = 1'b1;
      for (int i = 0; i < 16; i++) mem[i] = 16'h8100 + 16'(i);
   end
   always @(word or drive) if (drive) last = word;
   // ======================================================
   // command latch, outside the array space
   always @* begin
      if (!wr_en_n && !chip_sel_n && (reset_n || high_voltage_id_level)) begin
         lat_a = flash_addr[3:0];
         lat_d = {top_wire, dq_wire};
         lat_v = 1'b1;
      end
   end
   always @(posedge wr_en_n) begin
      if (lat_v && lat_d == 16'h0090) auto_sel = 1'b1;
      else if (lat_v && lat_d == 16'h00F0) auto_sel = 1'b0;
      else if (lat_v) mem[lat_a] = lat_d;
      lat_v = 1'b0;
   end
   always @(negedge reset_n) begin
      auto_sel = 1'b0;
      lat_v = 1'b0;
      ready_busy_n = 1'b0;
   end
   always @(posedge reset_n) ready_busy_n <= #(READY_NS) 1'b1;
endmodule : fbc_flash

// File: tb/fbc_host_test.sv
// testbench: flash bus controller against a behavioural flash
`timescale 1ns/1ps
module fbc_host_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, chip_sel_n, out_en_n, wr_en_n, reset_n, hv, byte_mode_n;
   logic flash_dq_oe, top_out, top_oe, top_drv, ready_busy_n;
   logic [18:0] flash_addr;
   logic [14:0] dq_out, dq_drv;
   wire [14:0] dq_wire = flash_dq_oe ? dq_out : dq_drv;
   wire top_wire = top_oe ? top_out : top_drv;
   int bad_count = 0;
   int n_tests = 0;
   always #12.5 core_clk = ~core_clk;
   fbc_host fbc_host_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n), .wr_en_n(wr_en_n), .reset_n(reset_n), .high_voltage_id_level(hv),
      .byte_mode_n(byte_mode_n), .flash_addr(flash_addr), .flash_dq_in(dq_wire),
      .flash_dq_out(dq_out), .flash_dq_oe(flash_dq_oe), .data_bit_top_in(top_wire),
      .data_bit_top_out(top_out), .data_bit_top_oe(top_oe), .ready_busy_n(ready_busy_n));
   fbc_flash fbc_flash_i (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
      .reset_n(reset_n), .high_voltage_id_level(hv), .byte_mode_n(byte_mode_n),
      .flash_addr(flash_addr), .dq_wire(dq_wire), .top_wire(top_wire), .dq_drv(dq_drv),
      .top_drv(top_drv), .ready_busy_n(ready_busy_n));
   // ======================================================
   // bus cycles
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      avs_write <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_rd
   task automatic op(input logic [2:0] c, input logic bm, input logic [19:0] a,
                     input logic [15:0] d);
      bus_wr(fbc_pkg::ADDR_OFS, {12'h000, a});
      bus_wr(fbc_pkg::WDATA_OFS, {16'h0000, d});
      bus_wr(fbc_pkg::CTRL_OFS, 32'h80000000 | {27'h0, bm, 1'b0, c});
      rd = 32'hFFFFFFFF;
      for (int i = 0; i < 2000 && rd[fbc_pkg::BUSY_BIT] !== 1'b0; i++) bus_rd(4'h0, rd);
      if (rd[fbc_pkg::BUSY_BIT] !== 1'b0) begin
         bad_count++;
         $display("FAIL %0t busy never cleared", $time);
      end
   endtask : op
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t data %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic bm, input logic [19:0] a, input logic [15:0] exp);
      op(fbc_pkg::CMD_READ, bm, a, 16'h0000);
      bus_rd(fbc_pkg::RDATA_OFS, rd);
      chk(bm ? {8'h00, rd[7:0]} : rd[15:0], exp);
   endtask : rd_chk
   // ======================================================
   // scenarios
   task automatic t_rw();
      rd_chk(1'b0, 20'h0000A, 16'h8105);
      op(fbc_pkg::CMD_WRITE, 1'b0, 20'h0000C, 16'h1234);
      op(fbc_pkg::CMD_WRITE, 1'b0, 20'h0000E, 16'hFEDC);
      rd_chk(1'b0, 20'h0000C, 16'h1234);
      rd_chk(1'b0, 20'h0000E, 16'hFEDC);
      rd_chk(1'b1, 20'h0000D, 16'h0012);
      rd_chk(1'b1, 20'h0000C, 16'h0034);
      $display("done read write byte");
   endtask : t_rw
   task automatic t_auto_reset();
      op(fbc_pkg::CMD_WRITE, 1'b0, 20'h00000, 16'h0090);
      rd_chk(1'b0, 20'h00002, 16'h005A);
      op(fbc_pkg::CMD_RESET, 1'b0, 20'h00000, 16'h0000);
      rd_chk(1'b0, 20'h00002, 16'h8101);
      op(fbc_pkg::CMD_UNPROT_WR, 1'b0, 20'h00012, 16'h0F0F);
      rd_chk(1'b0, 20'h00012, 16'h0F0F);
      $display("done autoselect reset unprotect");
   endtask : t_auto_reset
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #1000000;
      bad_count++;
      $display("FAIL %0t timeout", $time);
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      t_rw();
      t_auto_reset();
      end_of_test();
   end
endmodule : fbc_host_test
